//--- design/rsw_cfg.svh
// Constants for the reset supervisor and watchdog.
`ifndef RSW_CFG_SVH
`define RSW_CFG_SVH
`define RSW_ADDR_W           8
`define RSW_DATA_W           8
`define RSW_SFR_POWER_CONTROL_REG         8'h87
`define RSW_SFR_RELOAD       8'hA6
`define RSW_SFR_KEY          8'hAE
`define RSW_SFR_USB_IRQ_ENABLE_REG         8'hF1
`define RSW_SFR_USB_IRQ_STATUS_REG        8'hF2
`define RSW_POWER_CONTROL_REG_LVR_DIS_BIT 5
`define RSW_USB_IRQ_ENABLE_REG_BUS_RESET_CPU_ENABLE_BIT    6
`define RSW_USB_IRQ_STATUS_REG_BUS_RESET_FLAG_BIT   6
`define RSW_KEY_DISABLE      8'h55
`define RSW_KEY_RESET        8'h00
`define RSW_RELOAD_MAX       7'h7E
`define RSW_WDT_W            22
`define RSW_RELOAD_W         7
`define RSW_OSC_PER_MC       12
`define RSW_CLK_MHZ          100
`define RSW_LVR_HOLD_MS      10
`define RSW_LVR_HOLD_CYC     (`RSW_LVR_HOLD_MS * 1000 * `RSW_CLK_MHZ)
`define RSW_WDT_PULSE_EXP    15
`define RSW_SE0_MIN          4
`endif

//--- design/rsw_mc_div.sv
// Machine cycle enable divider, one pulse every N clocks.
`timescale 1ns/1ns
module rsw_mc_div #(
  parameter int unsigned DIV = 12
) (
  input  wire logic clk_in,
  input  wire logic arst_n_in,
  output logic      tick_out
);
  typedef struct packed {
    logic [7:0] cnt;
    logic       tick;
  } rsw_div_st_t;
  rsw_div_st_t st_r;
  rsw_div_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (st_r.cnt == 8'(DIV - 1)) begin
      st_nxt.cnt  = 8'h00;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + 8'h01;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick_out = st_r.tick;
endmodule : rsw_mc_div

//--- design/rsw_pkg.sv
// Types shared by the reset supervisor files.
package rsw_pkg;
  typedef enum logic [1:0] {
    RSW_RUN   = 2'b00,
    RSW_PULSE = 2'b01,
    RSW_HOLD  = 2'b11
  } rsw_wdt_state_t;
endpackage : rsw_pkg

//--- design/rsw_top.sv
// Reset supervisor: reset source merge, low supply hold, USB reset and watchdog.
`timescale 1ns/1ns
`include "rsw_cfg.svh"
module rsw_top
  import rsw_pkg::*;
#(
  parameter int unsigned LVR_HOLD_CYC = `RSW_LVR_HOLD_CYC,
  parameter int unsigned WDT_W        = `RSW_WDT_W,
  parameter int unsigned PULSE_EXP    = `RSW_WDT_PULSE_EXP,
  parameter int unsigned SE0_MIN      = `RSW_SE0_MIN
) (
  input  wire logic                   clk_in,
  input  wire logic                   arst_n_in,
  input  wire logic                   ext_reset_n_in,
  input  wire logic                   supply_low_in,
  input  wire logic                   usb_se0_in,
  input  wire logic                   sfr_wr_in,
  input  wire logic                   sfr_rd_in,
  input  wire logic [`RSW_ADDR_W-1:0] sfr_addr_in,
  input  wire logic [`RSW_DATA_W-1:0] sfr_wdata_in,
  output logic      [`RSW_DATA_W-1:0] sfr_rdata_out,
  output logic                        sys_reset_out,
  output logic                        plm_reset_n_out,
  output logic                        wdt_reset_out,
  output logic                        low_supply_reset_out,
  output logic                        bus_reset_flag_out
);
  import rsw_pkg::*;

  // Power-up enables the low supply reset; the bit disables it later when set and enables it again when cleared.
  typedef struct packed {
    logic                         lvr_dis;
    logic                         lvr_act;
    logic [31:0]                  lvr_cnt;
    logic [`RSW_DATA_W-1:0]       key;
    logic                         bus_reset_cpu_enable;
    logic                         bus_reset_flag;
    logic [3:0]                   se0_cnt;
    logic                         usb_rst;
    logic [WDT_W-1:0]             wdt;
    rsw_wdt_state_t               wst;
    logic                         wdt_rst;
    logic [PULSE_EXP-1:0]         pcnt;
    logic                         sys_rst;
    logic                         plm_rst_n;
    logic [`RSW_DATA_W-1:0]       rdata;
  } rsw_st_t;

  rsw_st_t st_r;
  rsw_st_t st_nxt;
  logic    mc_tick;
  logic    wdt_en;
  logic    key_wr;

  rsw_mc_div #(.DIV(`RSW_OSC_PER_MC)) u_div (
    .clk_in    (clk_in),
    .arst_n_in (arst_n_in),
    .tick_out  (mc_tick)
  );

  function automatic logic hit(input logic [`RSW_ADDR_W-1:0] a, input logic [`RSW_ADDR_W-1:0] b);
    hit = (a == b);
  endfunction : hit

  assign wdt_en = (st_r.key != `RSW_KEY_DISABLE);
  assign key_wr = sfr_wr_in && hit(sfr_addr_in, `RSW_SFR_KEY);

  always_comb begin
    st_nxt = st_r;
    // Power control bit; the low supply path has no idle or power-down gate.
    if (sfr_wr_in && hit(sfr_addr_in, `RSW_SFR_POWER_CONTROL_REG)) begin
      st_nxt.lvr_dis = sfr_wdata_in[`RSW_POWER_CONTROL_REG_LVR_DIS_BIT];
    end
    if (st_r.lvr_dis) begin
      st_nxt.lvr_act = 1'b0;
      st_nxt.lvr_cnt = 32'h0;
    end else if (supply_low_in) begin
      st_nxt.lvr_act = 1'b1;
      st_nxt.lvr_cnt = 32'h0;
    end else if (st_r.lvr_act) begin
      if (st_r.lvr_cnt >= LVR_HOLD_CYC - 1) begin
        st_nxt.lvr_act = 1'b0;
      end else begin
        st_nxt.lvr_cnt = st_r.lvr_cnt + 32'h1;
      end
    end

    // USB bus reset detection on machine cycle samples.
    if (sfr_wr_in && hit(sfr_addr_in, `RSW_SFR_USB_IRQ_ENABLE_REG)) begin
      st_nxt.bus_reset_cpu_enable = sfr_wdata_in[`RSW_USB_IRQ_ENABLE_REG_BUS_RESET_CPU_ENABLE_BIT];
    end
    if (sfr_wr_in && hit(sfr_addr_in, `RSW_SFR_USB_IRQ_STATUS_REG) && sfr_wdata_in[`RSW_USB_IRQ_STATUS_REG_BUS_RESET_FLAG_BIT]) begin
      st_nxt.bus_reset_flag = 1'b0;
    end
    st_nxt.usb_rst = 1'b0;
    if (!usb_se0_in) begin
      st_nxt.se0_cnt = 4'h0;
    end else if (mc_tick && st_r.se0_cnt != 4'hF) begin
      st_nxt.se0_cnt = st_r.se0_cnt + 4'h1;
    end
    if (st_r.se0_cnt >= 4'(SE0_MIN)) begin
      st_nxt.bus_reset_flag    = 1'b1;
      st_nxt.usb_rst = st_r.bus_reset_cpu_enable;
    end

    // Watchdog counter and pulse sequencer.
    case (st_r.wst)
      RSW_RUN: begin
        if (sfr_wr_in && hit(sfr_addr_in, `RSW_SFR_RELOAD)) begin
          st_nxt.wdt = {sfr_wdata_in[`RSW_RELOAD_W-1:0], {(WDT_W-`RSW_RELOAD_W){1'b0}}};
        end else if (mc_tick && wdt_en) begin
          if (&st_r.wdt) begin
            st_nxt.wdt  = '0;
            st_nxt.pcnt = '0;
            st_nxt.wst  = RSW_PULSE;
          end else begin
            st_nxt.wdt = st_r.wdt + 1'b1;
          end
        end
      end
      RSW_PULSE: begin
        if (mc_tick) begin
          if (&st_r.pcnt) begin
            st_nxt.wst = RSW_HOLD;
          end else begin
            st_nxt.pcnt = st_r.pcnt + 1'b1;
          end
        end
      end
      RSW_HOLD: begin
        st_nxt.wst = RSW_RUN;
      end
      default: begin
        st_nxt.wst = RSW_RUN;
      end
    endcase

    // Registered copy of the pulse state so the output comes from a flop.
    st_nxt.wdt_rst = (st_nxt.wst == RSW_PULSE);
    st_nxt.sys_rst = !ext_reset_n_in || st_r.lvr_act || st_r.usb_rst ||
                     (st_r.wst == RSW_PULSE);
    st_nxt.plm_rst_n = !st_nxt.sys_rst;

    // Internal reset restarts the watchdog cleared, and enabled unless a key write in the same cycle sets the key.
    if (st_r.sys_rst) begin
      st_nxt.key = `RSW_KEY_RESET;
      if (st_r.wst == RSW_RUN) begin
        st_nxt.wdt = '0;
      end
    end
    if (key_wr) begin
      st_nxt.key = sfr_wdata_in;
    end

    st_nxt.rdata = '0;
    if (sfr_rd_in) begin
      if (hit(sfr_addr_in, `RSW_SFR_KEY)) begin
        st_nxt.rdata = st_r.key;
      end else if (hit(sfr_addr_in, `RSW_SFR_POWER_CONTROL_REG)) begin
        st_nxt.rdata[`RSW_POWER_CONTROL_REG_LVR_DIS_BIT] = st_r.lvr_dis;
      end else if (hit(sfr_addr_in, `RSW_SFR_USB_IRQ_ENABLE_REG)) begin
        st_nxt.rdata[`RSW_USB_IRQ_ENABLE_REG_BUS_RESET_CPU_ENABLE_BIT] = st_r.bus_reset_cpu_enable;
      end else if (hit(sfr_addr_in, `RSW_SFR_USB_IRQ_STATUS_REG)) begin
        st_nxt.rdata[`RSW_USB_IRQ_STATUS_REG_BUS_RESET_FLAG_BIT] = st_r.bus_reset_flag;
      end
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_r           <= '0;
      st_r.lvr_act   <= 1'b1;
      st_r.sys_rst   <= 1'b1;
      st_r.plm_rst_n <= 1'b0;
      st_r.wst       <= RSW_RUN;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sfr_rdata_out        = st_r.rdata;
  assign sys_reset_out        = st_r.sys_rst;
  assign plm_reset_n_out      = st_r.plm_rst_n;
  assign wdt_reset_out        = st_r.wdt_rst;
  assign low_supply_reset_out = st_r.lvr_act;
  assign bus_reset_flag_out   = st_r.bus_reset_flag;
endmodule : rsw_top

//--- verif/rsw_board.sv
// Board reset circuit and upstream USB host model.
`timescale 1ns/1ns
module rsw_board #(parameter int unsigned PWRUP = 100) (
  input  wire logic clk_in,
  output logic      ext_reset_n_out, supply_low_out, usb_se0_out
);
  logic [2:0] act = 3'b001;
  assign {usb_se0_out, supply_low_out} = act[2:1];
  assign ext_reset_n_out = !act[0];
  initial begin
    repeat (PWRUP) @(posedge clk_in);
    #1 act = 3'b000;
  end
  task automatic drive(input logic [2:0] m, input int n);
    @(posedge clk_in) #1 act = m;
    repeat (n) @(posedge clk_in);
    #1 act = 3'b000;
  endtask : drive
endmodule : rsw_board

//--- verif/rsw_top_chk.sv
// Port assertions for the reset supervisor.
`timescale 1ns/1ns
module rsw_top_chk #(parameter int unsigned PULSE_EXP = 15, parameter int unsigned SE0_MIN = 4) (
  input wire logic clk_in, arst_n_in, ext_reset_n_in, supply_low_in, usb_se0_in, sfr_wr_in, sfr_rd_in,
  input wire logic [7:0] sfr_addr_in, sfr_wdata_in, sfr_rdata_out,
  input wire logic sys_reset_out, plm_reset_n_out, wdt_reset_out, low_supply_reset_out, bus_reset_flag_out
);
  localparam int unsigned PW = 12 << PULSE_EXP;
  logic        en_r;
  logic [31:0] hi_r, se_r;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      en_r <= 1'b0;
      hi_r <= '0;
      se_r <= '0;
    end else begin
      en_r <= (sfr_wr_in && sfr_addr_in == 8'hF1) ? sfr_wdata_in[6] : en_r;
      hi_r <= wdt_reset_out ? hi_r + 1 : '0;
      se_r <= usb_se0_in ? se_r + 1 : '0;
    end
  end
  sequence s_sys_next;
    ##1 sys_reset_out ##1 sys_reset_out;
  endsequence
  sequence s_se0_long;
    usb_se0_in && !en_r && se_r == 12 * SE0_MIN + 4;
  endsequence
  a_plm_inverse: assert property (plm_reset_n_out == !sys_reset_out) else $error("plm mismatch");
  a_ext_merge: assert property (!ext_reset_n_in |-> ##[1:3] sys_reset_out) else $error("ext");
  a_supply_merge: assert property (low_supply_reset_out |-> ##[1:2] sys_reset_out) else $error("lsr");
  a_supply_hold: assert property ($fell(supply_low_in) && low_supply_reset_out |=> low_supply_reset_out[*8])
    else $error("hold");
  a_wdt_merge: assert property ($rose(wdt_reset_out) |-> s_sys_next) else $error("wdt");
  a_wdt_width: assert property ($fell(wdt_reset_out) |-> hi_r >= PW - 11 && hi_r <= PW + 1) else $error("width");
  a_se0_flag: assert property (s_se0_long |-> bus_reset_flag_out) else $error("flag");
  a_bus_merge: assert property ($rose(bus_reset_flag_out) && en_r |-> ##[1:2] sys_reset_out) else $error("bus");
endmodule : rsw_top_chk
bind rsw_top rsw_top_chk #(.PULSE_EXP(PULSE_EXP), .SE0_MIN(SE0_MIN)) u_chk (.*);

//--- verif/tb.sv
// Self-checking bench for the reset supervisor.
`timescale 1ns/1ns
module tb;
  logic clk_in, arst_n_in, sfr_wr_in, sfr_rd_in, ext_reset_n_in, supply_low_in, usb_se0_in;
  logic [7:0] sfr_addr_in, sfr_wdata_in, sfr_rdata_out, d, v;
  logic sys_reset_out, plm_reset_n_out, wdt_reset_out, low_supply_reset_out, bus_reset_flag_out;
  int failures, total_checks, n;
  rsw_top #(.LVR_HOLD_CYC(20), .WDT_W(8), .PULSE_EXP(3)) dut (.*);
  rsw_board bd (.clk_in(clk_in), .ext_reset_n_out(ext_reset_n_in), .supply_low_out(supply_low_in),
    .usb_se0_out(usb_se0_in));
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  task automatic finish_test;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [7:0] g, e);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("wrong value at %0t: %h not %h", $time, g, e);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_in);
    #1;
  endtask : cyc
  task automatic acc(input logic w, input logic [7:0] a, x);
    cyc(1);
    {sfr_wr_in, sfr_rd_in, sfr_addr_in, sfr_wdata_in} = {w, !w, a, x};
    cyc(1);
    {sfr_wr_in, sfr_rd_in} = 2'b00;
    d = sfr_rdata_out;
  endtask : acc
  task automatic hang(input logic s, input int lim);
    n = 0;
    while ((s ? sys_reset_out : wdt_reset_out) !== 1'b1 && n < lim) begin
      cyc(1);
      n++;
    end
  endtask : hang
  function automatic int due(input logic [6:0] r);
    return 12 * (256 - 2 * r);
  endfunction : due
  task automatic wdt_run(input logic [7:0] x);
    acc(1'b1, 8'hA6, x);
    hang(1'b0, 4000);
    chk(8'(n >= due(x[6:0]) - 11 && n <= due(x[6:0]) + 2), 8'h01);
    cyc(200);
  endtask : wdt_run
  initial begin
    {arst_n_in, sfr_wr_in, sfr_rd_in, sfr_addr_in, sfr_wdata_in} = '0;
    failures = 0;
    total_checks = 0;
    void'($urandom(20));
    cyc(6);
    arst_n_in = 1'b1;
    chk({sys_reset_out, plm_reset_n_out}, 8'h02);
    cyc(130);
    chk({sys_reset_out, plm_reset_n_out}, 8'h01);
    repeat (3) begin
      v = 8'($urandom);
      if (v == 8'h55) v = 8'h54;
      acc(1'b1, 8'hAE, v);
      acc(1'b0, 8'hAE, 8'h00);
      chk(d, v);
    end
    acc(1'b0, 8'hA6, 8'h00);
    chk(d, 8'h00);
    wdt_run(8'h00);
    wdt_run(8'hFE);
    repeat (2) begin
      v = 8'($urandom_range(254));
      if (v[6:0] == 7'h7F) v = 8'h7E;
      wdt_run(v);
    end
    repeat (3) begin
      acc(1'b1, 8'hA6, 8'h00);
      hang(1'b0, 2000);
      chk(8'(n == 2000), 8'h01);
    end
    acc(1'b1, 8'hAE, 8'h55);
    hang(1'b0, 3500);
    chk(8'(n == 3500), 8'h01);
    acc(1'b1, 8'hAE, 8'h54);
    wdt_run(8'h40);
    bd.drive(3'b001, 4 + $urandom_range(6));
    chk({sys_reset_out, plm_reset_n_out}, 8'h02);
    bd.drive(3'b010, 10);
    chk({low_supply_reset_out, sys_reset_out}, 8'h03);
    cyc(15);
    chk(low_supply_reset_out, 8'h01);
    cyc(10);
    chk({low_supply_reset_out, sys_reset_out}, 8'h00);
    acc(1'b1, 8'h87, 8'h20);
    bd.drive(3'b010, 10);
    chk(low_supply_reset_out, 8'h00);
    bd.drive(3'b100, 30);
    chk(bus_reset_flag_out, 8'h00);
    bd.drive(3'b100, 50 + $urandom_range(30));
    cyc(2);
    chk({bus_reset_flag_out, sys_reset_out}, 8'h02);
    acc(1'b1, 8'hF2, 8'h40);
    chk(bus_reset_flag_out, 8'h00);
    acc(1'b1, 8'hF1, 8'h40);
    fork
      bd.drive(3'b100, 60);
      hang(1'b1, 60);
    join
    chk(8'(n < 60), 8'h01);
    finish_test();
  end
  initial begin
    repeat (40000) @(posedge clk_in);
    failures++;
    finish_test();
  end
endmodule : tb
